// file: include/scg_pkg.sv
// Purpose: constants and types of the sleep-mode clock gating control block
// Assumes: 32-bit AXI4-Lite register bus, word-aligned registers
// Notes:   byte offsets are relative to the block base
package scg_pkg;

	localparam int unsigned ADDR_W = 12;

	// register byte offsets
	localparam logic [11:0] OFS_SLEEP_GATE  = 12'h110;
	localparam logic [11:0] OFS_IRQ_STATUS  = 12'h200;
	localparam logic [11:0] OFS_IRQ_CLEAR   = 12'h204;
	localparam logic [11:0] OFS_IRQ_ENABLE  = 12'h208;
	localparam logic [11:0] OFS_GATE_STATE  = 12'h20C;

	// whole-register reset value of sleep_clock_gate_ctrl0
	localparam logic [31:0] SLEEP_GATE_RST  = 32'h0000_0040;

	// field positions in sleep_clock_gate_ctrl0
	localparam int unsigned BIT_PWM         = 20;
	localparam int unsigned BIT_CONV0       = 16;
	localparam int unsigned BIT_WDOG        = 3;
	localparam int unsigned SPEED_LO        = 8;
	localparam int unsigned SPEED_W         = 2;

	// converter_sample_speed encodings
	localparam logic [1:0]  SPEED_125K      = 2'h0;
	localparam logic [1:0]  SPEED_250K      = 2'h1;

	// gated peripheral indices
	localparam int unsigned NUM_GATE        = 3;
	localparam int unsigned GATE_PWM        = 0;
	localparam int unsigned GATE_CONV0      = 1;
	localparam int unsigned GATE_WDOG       = 2;

	// gate state register layout
	localparam int unsigned STATE_MODE_LO   = 4;
	localparam int unsigned STATE_AUTO_BIT  = 8;

	// bus responses and byte lanes
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
	localparam int unsigned NUM_LANE        = 4;

	// power mode of the core
	typedef enum logic [1:0] {
		SCG_MODE_RUN   = 2'b00,
		SCG_MODE_SLEEP = 2'b01,
		SCG_MODE_DEEP  = 2'b10
	} scg_mode_e;

endpackage

// file: tb/scg_sleep_gate_asserts.sv
// Purpose: port-level checks of the sleep gate block
// Assumes: single clock domain, async active-low reset
// Notes:   bound to every scg_sleep_gate instance
`timescale 1ns/1ps

module scg_sleep_gate_chk (
	// clock and reset
	input wire logic                         core_clk,
	input wire logic                         rst_n,
	// bus
	input wire logic                         s_axi_awready,
	input wire logic                         s_axi_wready,
	input wire logic [1:0]                   s_axi_bresp,
	input wire logic                         s_axi_bvalid,
	input wire logic                         s_axi_bready,
	input wire logic                         s_axi_arvalid,
	input wire logic                         s_axi_arready,
	input wire logic [31:0]                  s_axi_rdata,
	input wire logic                         s_axi_rvalid,
	input wire logic                         s_axi_rready,
	// gating
	input wire scg_pkg::scg_mode_e           pwr_mode,
	input wire logic                         auto_gating_select,
	input wire logic [scg_pkg::NUM_GATE-1:0] run_gate,
	input wire logic [scg_pkg::NUM_GATE-1:0] deep_gate,
	input wire logic [scg_pkg::NUM_GATE-1:0] periph_access,
	input wire logic [scg_pkg::NUM_GATE-1:0] periph_fault,
	input wire logic [scg_pkg::NUM_GATE-1:0] periph_clk_en,
	input wire logic                         irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////
	chk_fault_now: assert property (
		periph_fault == (periph_access & ~periph_clk_en)) else $error("fault wrong");
	chk_run_select: assert property (
		!auto_gating_select |=> periph_clk_en == $past(run_gate)) else $error("run set");
	chk_deep_select: assert property (
		auto_gating_select && pwr_mode == scg_pkg::SCG_MODE_DEEP
		|=> periph_clk_en == $past(deep_gate)) else $error("deep set");
	chk_reset_off: assert property (
		$rose(rst_n) |-> periph_clk_en == '0 && !irq) else $error("not off");
	chk_bresp_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("bresp dropped");
	chk_rdata_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("rdata dropped");
	chk_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
	chk_write_busy: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready while busy");
	////////////////////////////////////////////////////////////////////////
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property (|periph_fault);
	cover property (irq);
endmodule

bind scg_sleep_gate scg_sleep_gate_chk u_scg_sleep_gate_chk (.*);

// file: tb/scg_sleep_gate_tb.sv
// Purpose: register and gating tests of the sleep gate block
// Assumes: AXI4-Lite master tasks, 25 MHz clock
// Notes:   expected values from the field map constants
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
	$display("unexpected at %0t: got %h exp %h", $time, a, b); end end

module scg_sleep_gate_tb;
	logic               core_clk, rst_n;
	logic [11:0]        s_axi_awaddr, s_axi_araddr;
	logic [2:0]         s_axi_awprot, s_axi_arprot;
	logic [31:0]        s_axi_wdata, s_axi_rdata;
	logic [3:0]         s_axi_wstrb;
	logic [1:0]         s_axi_bresp, s_axi_rresp, converter_sample_speed;
	logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic               s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic               s_axi_rvalid, s_axi_rready, auto_gating_select, irq;
	scg_pkg::scg_mode_e pwr_mode;
	logic [2:0]         run_gate, deep_gate, periph_access, periph_fault, periph_clk_en;
	int                 error_cnt, checks_done;
	int unsigned        gbit[3] = '{scg_pkg::BIT_PWM, scg_pkg::BIT_CONV0, scg_pkg::BIT_WDOG};
	localparam logic [11:0] GATE = scg_pkg::OFS_SLEEP_GATE;

	scg_sleep_gate u_scg_sleep_gate (.*);

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////////////
	task give_verdict;
		if (error_cnt == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
			input logic [1:0] r);
		int n;
		n = 0;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 50);
		s_axi_bready <= 1'b0;
		if (!s_axi_bvalid) begin
			error_cnt++;
			give_verdict();
		end
		`CHK(s_axi_bresp, r)
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		n = 0;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 50);
		s_axi_rready <= 1'b0;
		if (!s_axi_rvalid) begin
			error_cnt++;
			give_verdict();
		end
		`CHK(s_axi_rdata, d)
		`CHK(s_axi_rresp, r)
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		{rst_n, s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
		{s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, run_gate, deep_gate, periph_access} = '0;
		{error_cnt, checks_done} = '0;
		auto_gating_select = 1'b1;
		pwr_mode = scg_pkg::SCG_MODE_SLEEP;
		tick(16);
		rst_n <= 1'b1;
		rd(GATE, scg_pkg::SLEEP_GATE_RST, scg_pkg::RESP_OKAY);
		`CHK(periph_clk_en, 3'h0)
		// speed written as the faster legal rate, bit 9 left clear
		wr(GATE, 32'hFFFF_FDFF, 4'hF, scg_pkg::RESP_OKAY);
		rd(GATE, 32'h0011_0148, scg_pkg::RESP_OKAY);
		tick(2);
		`CHK(periph_clk_en, 3'h7)
		// lane 2 untouched keeps the two upper gates
		wr(GATE, 32'h0, 4'hB, scg_pkg::RESP_OKAY);
		rd(GATE, 32'h0011_0040, scg_pkg::RESP_OKAY);
		for (int i = 0; i < 3; i++) begin
			wr(GATE, 32'h1 << gbit[i], 4'hF, scg_pkg::RESP_OKAY);
			tick(2);
			`CHK(periph_clk_en, 3'h1 << i)
			periph_access <= 3'h7;
			@(negedge core_clk);
			`CHK(periph_fault, ~(3'h1 << i))
			tick(1);
			periph_access <= 3'h0;
		end
		for (int s = 1; s >= 0; s--) begin
			wr(GATE, 32'(s) << scg_pkg::SPEED_LO, 4'hF, scg_pkg::RESP_OKAY);
			tick(2);
			`CHK(converter_sample_speed, 2'(s))
		end
		run_gate <= 3'h5;
		deep_gate <= 3'h2;
		auto_gating_select <= 1'b0;
		tick(2);
		`CHK(periph_clk_en, 3'h5)
		auto_gating_select <= 1'b1;
		pwr_mode <= scg_pkg::SCG_MODE_DEEP;
		tick(2);
		`CHK(periph_clk_en, 3'h2)
		pwr_mode <= scg_pkg::SCG_MODE_SLEEP;
		tick(2);
		`CHK(periph_clk_en, 3'h0)
		// masked fault sets status without raising irq
		wr(scg_pkg::OFS_IRQ_CLEAR, 32'h7, 4'hF, scg_pkg::RESP_OKAY);
		wr(scg_pkg::OFS_IRQ_ENABLE, 32'h2, 4'hF, scg_pkg::RESP_OKAY);
		periph_access <= 3'h1;
		tick(1);
		periph_access <= 3'h0;
		tick(2);
		`CHK(irq, 1'b0)
		rd(scg_pkg::OFS_IRQ_STATUS, 32'h1, scg_pkg::RESP_OKAY);
		rd(scg_pkg::OFS_IRQ_ENABLE, 32'h2, scg_pkg::RESP_OKAY);
		rd(scg_pkg::OFS_GATE_STATE, 32'h0000_0110, scg_pkg::RESP_OKAY);
		periph_access <= 3'h2;
		tick(1);
		periph_access <= 3'h0;
		tick(2);
		`CHK(irq, 1'b1)
		wr(scg_pkg::OFS_IRQ_CLEAR, 32'h2, 4'hF, scg_pkg::RESP_OKAY);
		`CHK(irq, 1'b0)
		wr(12'h300, 32'h1, 4'hF, scg_pkg::RESP_SLVERR);
		rd(12'h300, 32'h0, scg_pkg::RESP_SLVERR);
		rst_n <= 1'b0;
		tick(2);
		rst_n <= 1'b1;
		rd(GATE, scg_pkg::SLEEP_GATE_RST, scg_pkg::RESP_OKAY);
		`CHK(periph_clk_en, 3'h0)
		rd(scg_pkg::OFS_IRQ_ENABLE, 32'h0, scg_pkg::RESP_OKAY);
		give_verdict();
	end
endmodule

// file: verilog/scg_sleep_gate.sv
// Purpose: sleep-mode clock gating control register with AXI4-Lite access
// Assumes: single clock core_clk, async active-low reset, synchronous inputs
// Notes:   enables drive external gating cells; one cycle from select to enable
//          write response one edge after address and data are both held
//          read answer one edge after the read address is taken
//          bit 6 of the control image reads one, other reserved bits read zero
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps

module scg_sleep_gate #(
	parameter int unsigned ADDR_W = scg_pkg::ADDR_W
) (
	// clock and reset
	input  wire logic                          core_clk,
	input  wire logic                          rst_n,
	// axi4-lite write address
	input  wire logic [ADDR_W-1:0]             s_axi_awaddr,
	input  wire logic [2:0]                    s_axi_awprot,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	// axi4-lite read address
	input  wire logic [ADDR_W-1:0]             s_axi_araddr,
	input  wire logic [2:0]                    s_axi_arprot,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	// axi4-lite read data
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	// power mode and companion gating sets
	input  wire scg_pkg::scg_mode_e            pwr_mode,
	input  wire logic                          auto_gating_select,
	input  wire logic [scg_pkg::NUM_GATE-1:0]  run_gate,
	input  wire logic [scg_pkg::NUM_GATE-1:0]  deep_gate,
	// gated peripherals
	input  wire logic [scg_pkg::NUM_GATE-1:0]  periph_access,
	output logic [scg_pkg::NUM_GATE-1:0]       periph_fault,
	output logic [scg_pkg::NUM_GATE-1:0]       periph_clk_en,
	output logic [scg_pkg::SPEED_W-1:0]        converter_sample_speed,
	// interrupt
	output logic                               irq
);

	////////////////////////////////////////////////////////////////////////////////

	typedef struct packed {
		logic [scg_pkg::NUM_GATE-1:0] sleep_gate;
		logic [scg_pkg::SPEED_W-1:0]  speed;
		logic [scg_pkg::NUM_GATE-1:0] clk_en;
		logic [scg_pkg::NUM_GATE-1:0] irq_sts;
		logic [scg_pkg::NUM_GATE-1:0] irq_en;
		logic                         aw_have;
		logic [ADDR_W-1:0]            aw_addr;
		logic                         w_have;
		logic [31:0]                  w_data;
		logic [3:0]                   w_strb;
		logic                         bvalid;
		logic [1:0]                   bresp;
		logic                         rvalid;
		logic [31:0]                  rdata;
		logic [1:0]                   rresp;
	} scg_state_s;

	scg_state_s                   state_ff;
	scg_state_s                   nxt_state;
	logic [31:0]                  ctrl_word;
	logic [31:0]                  state_word;
	logic [31:0]                  merged;
	logic [scg_pkg::NUM_GATE-1:0] sel_gate;
	logic [scg_pkg::NUM_GATE-1:0] clr_bits;
	logic [ADDR_W-1:0]            wr_addr;
	logic [ADDR_W-1:0]            rd_addr;
	logic                         do_wr;
	logic                         do_rd;
	logic [scg_pkg::NUM_GATE-1:0] nxt_sts;
	logic [31:0]                  rd_word;
	logic [1:0]                   rd_resp;

	////////////////////////////////////////////////////////////////////////////////
	// register map, byte offsets from the block base
	//
	// sleep gate control, read-write:
	//   pulse-width gate, converter 0 gate, two-bit sample speed, watchdog gate;
	//   a cleared gate bit leaves its unit unclocked while the core sleeps with auto gating selected
	// interrupt status, read-only:
	//   one sticky bit per gated unit, set by an access while it is unclocked
	// interrupt clear, write-only:
	//   ones in lane 0 clear status bits; a fault in the same cycle wins
	// interrupt enable, read-write:
	//   one bit per gated unit; irq is high while an enabled status bit is set
	// gate state, read-only:
	//   enables in force, power mode and the auto gating select
	//
	// unmapped addresses answer with an error and change nothing;
	// writes to the read-only images are answered and dropped

	////////////////////////////////////////////////////////////////////////////////
	// handshake outputs

	assign s_axi_awready = ~state_ff.aw_have & ~state_ff.bvalid;
	assign s_axi_wready  = ~state_ff.w_have & ~state_ff.bvalid;
	assign s_axi_arready = ~state_ff.rvalid;
	assign s_axi_bvalid  = state_ff.bvalid;
	assign s_axi_bresp   = state_ff.bresp;
	assign s_axi_rvalid  = state_ff.rvalid;
	assign s_axi_rdata   = state_ff.rdata;
	assign s_axi_rresp   = state_ff.rresp;

	assign periph_clk_en          = state_ff.clk_en;
	assign converter_sample_speed = state_ff.speed;
	assign irq                    = |(state_ff.irq_sts & state_ff.irq_en);

	// one slice per gated unit
	for (genvar g = 0; g < scg_pkg::NUM_GATE; g++) begin : g_gate
		// unclocked unit answers with a fault instead of a normal access
		assign periph_fault[g] = periph_access[g] & ~state_ff.clk_en[g];
		// set wins over a clear in the same cycle, so no fault is lost
		assign nxt_sts[g]      = (state_ff.irq_sts[g] & ~clr_bits[g]) | periph_fault[g];
	end

	assign do_wr   = state_ff.aw_have & state_ff.w_have & ~state_ff.bvalid;
	assign do_rd   = s_axi_arvalid & ~state_ff.rvalid;
	// low address bits ignored: every register is one aligned word
	assign wr_addr = {state_ff.aw_addr[ADDR_W-1:2], 2'b00};
	assign rd_addr = {s_axi_araddr[ADDR_W-1:2], 2'b00};

	////////////////////////////////////////////////////////////////////////////////
	// register images

	always_comb begin
		// reserved bits stay at their reset image, writable fields overlaid
		ctrl_word = scg_pkg::SLEEP_GATE_RST;
		ctrl_word[scg_pkg::BIT_PWM]   = state_ff.sleep_gate[scg_pkg::GATE_PWM];
		ctrl_word[scg_pkg::BIT_CONV0] = state_ff.sleep_gate[scg_pkg::GATE_CONV0];
		ctrl_word[scg_pkg::BIT_WDOG]  = state_ff.sleep_gate[scg_pkg::GATE_WDOG];
		ctrl_word[scg_pkg::SPEED_LO +: scg_pkg::SPEED_W] = state_ff.speed;
	end

	always_comb begin
		state_word = '0;
		state_word[scg_pkg::NUM_GATE-1:0] = state_ff.clk_en;
		state_word[scg_pkg::STATE_MODE_LO +: $bits(pwr_mode)] = pwr_mode;
		state_word[scg_pkg::STATE_AUTO_BIT] = auto_gating_select;
	end

	// byte-lane merge of write data over the current control image
	always_comb begin
		merged = ctrl_word;
		for (int i = 0; i < scg_pkg::NUM_LANE; i++) begin
			if (state_ff.w_strb[i]) begin
				merged[8*i +: 8] = state_ff.w_data[8*i +: 8];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register decode

	// clear strobe of the sticky status, lane 0 only
	always_comb begin
		clr_bits = '0;
		if (do_wr && (wr_addr == scg_pkg::OFS_IRQ_CLEAR) && state_ff.w_strb[0]) begin
			clr_bits = state_ff.w_data[scg_pkg::NUM_GATE-1:0];
		end
	end

	// read image of the address on the bus; unmapped reads give zero and an error
	always_comb begin
		rd_word = '0;
		rd_resp = scg_pkg::RESP_OKAY;
		case (rd_addr)
			scg_pkg::OFS_SLEEP_GATE: begin
				rd_word = ctrl_word;
			end
			scg_pkg::OFS_IRQ_STATUS: begin
				rd_word[scg_pkg::NUM_GATE-1:0] = state_ff.irq_sts;
			end
			scg_pkg::OFS_IRQ_ENABLE: begin
				rd_word[scg_pkg::NUM_GATE-1:0] = state_ff.irq_en;
			end
			scg_pkg::OFS_IRQ_CLEAR: begin
				// write-only: reads back zero
				rd_word = '0;
			end
			scg_pkg::OFS_GATE_STATE: begin
				rd_word = state_word;
			end
			default: begin
				rd_resp = scg_pkg::RESP_SLVERR;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// mode selection of the gating set

	always_comb begin
		sel_gate = run_gate;
		// without auto gating the run set stays in force in every mode
		if (auto_gating_select) begin
			case (pwr_mode)
				scg_pkg::SCG_MODE_RUN: begin
					sel_gate = run_gate;
				end
				scg_pkg::SCG_MODE_SLEEP: begin
					sel_gate = state_ff.sleep_gate;
				end
				scg_pkg::SCG_MODE_DEEP: begin
					sel_gate = deep_gate;
				end
				default: begin
					sel_gate = run_gate;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		nxt_state = state_ff;

		nxt_state.clk_en = sel_gate;

		// address and data captured independently, in either order
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_state.aw_have = 1'b1;
			nxt_state.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_state.w_have = 1'b1;
			nxt_state.w_data = s_axi_wdata;
			nxt_state.w_strb = s_axi_wstrb;
		end

		if (do_wr) begin
			nxt_state.aw_have = 1'b0;
			nxt_state.w_have  = 1'b0;
			nxt_state.bvalid  = 1'b1;
			nxt_state.bresp   = scg_pkg::RESP_OKAY;
			case (wr_addr)
				scg_pkg::OFS_SLEEP_GATE: begin
					// only writable fields are taken, reserved bits ignored
					nxt_state.sleep_gate[scg_pkg::GATE_PWM]   = merged[scg_pkg::BIT_PWM];
					nxt_state.sleep_gate[scg_pkg::GATE_CONV0] = merged[scg_pkg::BIT_CONV0];
					nxt_state.sleep_gate[scg_pkg::GATE_WDOG]  = merged[scg_pkg::BIT_WDOG];
					nxt_state.speed = merged[scg_pkg::SPEED_LO +: scg_pkg::SPEED_W];
				end
				scg_pkg::OFS_IRQ_CLEAR: begin
					// the clear itself is taken by the decode above
					nxt_state.bresp = scg_pkg::RESP_OKAY;
				end
				scg_pkg::OFS_IRQ_ENABLE: begin
					if (state_ff.w_strb[0]) begin
						nxt_state.irq_en = state_ff.w_data[scg_pkg::NUM_GATE-1:0];
					end
				end
				scg_pkg::OFS_IRQ_STATUS, scg_pkg::OFS_GATE_STATE: begin
					nxt_state.bresp = scg_pkg::RESP_OKAY;
				end
				default: begin
					nxt_state.bresp = scg_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (state_ff.bvalid && s_axi_bready) begin
			nxt_state.bvalid = 1'b0;
		end

		// a fault in the clearing cycle survives the clear
		nxt_state.irq_sts = nxt_sts;

		// read data is registered so it stands until rready
		if (do_rd) begin
			nxt_state.rvalid = 1'b1;
			nxt_state.rdata  = rd_word;
			nxt_state.rresp  = rd_resp;
		end else if (state_ff.rvalid && s_axi_rready) begin
			nxt_state.rvalid = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			// all units start unclocked; in sleep with auto gating software must enable what it needs
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

endmodule
